// file: isbf_core_model.sv
`timescale 1ns/10ps
// ==========================================================
// Core and interrupt sources
// ==========================================================
module isbf_core_model (
    input wire logic clk,
    output logic [16:0] src_event,
    output logic [16:0] src_taken,
    output logic acc_valid,
    output logic [31:0] acc_addr,
    output logic [1:0] acc_size,
    output logic acc_write,
    output logic acc_priv
);
    initial begin
        src_event = 17'h0_0000;
        src_taken = 17'h0_0000;
        acc_valid = 1'b0;
        acc_addr = 32'h0000_0000;
        acc_size = 2'h2;
        acc_write = 1'b0;
        acc_priv = 1'b1;
    end

    task automatic pulse(input logic [16:0] ev, input logic [16:0] tk);
        @(posedge clk);
        src_event <= ev;
        src_taken <= tk;
        @(posedge clk);
        src_event <= 17'h0_0000;
        src_taken <= 17'h0_0000;
    endtask

    // Qualifiers are inverted outside an access so a stale address is never mistaken for a live one.
    task automatic access(input logic [31:0] a, input logic [1:0] sz, input logic wr, input logic pv);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_size <= sz;
        acc_write <= wr;
        acc_priv <= pv;
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_addr <= ~a;
        acc_size <= ~sz;
        acc_write <= ~wr;
        acc_priv <= ~pv;
    endtask
endmodule

// file: isbf_fault_check.sv
`timescale 1ns/10ps
module isbf_fault_check (
    input wire logic [31:0] acc_addr,
    input wire logic [1:0] acc_size,
    input wire logic acc_write,
    input wire logic acc_priv,
    output logic width_fault,
    output logic prot_fault,
    output logic rsvd_fault
);

    // ==========================================================
    // Region decode
    // ==========================================================
    logic in_apb;
    logic in_sys;
    logic in_prot_ram;
    logic above_flash;
    logic above_ram;

    always_comb begin
        in_apb = (acc_addr >= isbf_pkg::APB_BASE) && (acc_addr <= isbf_pkg::APB_END);
        in_sys = ((acc_addr >= isbf_pkg::APB_BASE) && (acc_addr <= isbf_pkg::SYS_APB_END))
            || ((acc_addr >= isbf_pkg::SYS_AHB_BASE) && (acc_addr <= isbf_pkg::SYS_AHB_END));
        in_prot_ram = (acc_addr >= isbf_pkg::RAM_BASE) && (acc_addr <= isbf_pkg::PROT_RAM_TOP);
        above_flash = (acc_addr > isbf_pkg::FLASH_TOP) && (acc_addr <= isbf_pkg::FLASH_WIN_END);
        above_ram = (acc_addr > isbf_pkg::RAM_TOP) && (acc_addr <= isbf_pkg::RAM_WIN_END);
    end

    // ==========================================================
    // Cause classification
    // ==========================================================
    always_comb begin
        width_fault = (in_apb && (acc_size != isbf_pkg::ISBF_SIZE_WORD))
            || ((acc_size == isbf_pkg::ISBF_SIZE_WORD) && (acc_addr[1:0] != isbf_pkg::WORD_ALIGN));
        prot_fault = acc_write && !acc_priv && (in_sys || in_prot_ram);
        // Every 4 kB block shares one last-register offset here.
        rsvd_fault = (in_apb && (acc_addr[11:0] > isbf_pkg::APB_LAST_OFS))
            || above_flash || above_ram;
    end

endmodule

// file: isbf_pkg.sv
package isbf_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [31:0] ADDR_ACTIVE = 32'h0000_0300;
    localparam logic [31:0] ADDR_FAULT = 32'h0000_0d3c;
    localparam logic [31:0] ADDR_MISSED = 32'h4000_a820;
    localparam logic [31:0] ADDR_EVT_STATUS = 32'h0000_0400;
    localparam logic [31:0] ADDR_EVT_MASK = 32'h0000_0404;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

    // ==========================================================
    // Field layouts
    // ==========================================================
    localparam int NUM_SRC = 17;
    localparam int MISS_LO = 2;
    localparam int MISS_HI = 15;
    localparam logic [16:0] MISSED_MASK = 17'h0_fffc;
    localparam int SRC_TIMER_ONE = 0;
    localparam int SRC_TIMER_TWO = 1;
    localparam int SRC_MANAGEMENT = 2;
    localparam int SRC_BASEBAND = 3;
    localparam int SRC_SLEEP_TIMER = 4;
    localparam int SRC_SERIAL_ONE = 5;
    localparam int SRC_SERIAL_TWO = 6;
    localparam int SRC_SECURITY = 7;
    localparam int SRC_RADIO_TIMER = 8;
    localparam int SRC_RADIO_TX = 9;
    localparam int SRC_RADIO_RX = 10;
    localparam int SRC_CONVERTER = 11;
    localparam int SRC_EXT_A = 12;
    localparam int SRC_EXT_D = 15;
    localparam int SRC_DEBUG = 16;

    localparam int FLT_OVERFLOW = 0;
    localparam int FLT_RESERVED = 1;
    localparam int FLT_PROTECT = 2;
    localparam int FLT_WIDTH = 3;
    localparam int FLT_BITS = 4;

    localparam int EVT_MISSED = 0;
    localparam int EVT_FAULT = 1;
    localparam int EVT_BITS = 2;

    typedef enum logic [1:0] {
        ISBF_SIZE_BYTE = 2'b00,
        ISBF_SIZE_HALF = 2'b01,
        ISBF_SIZE_WORD = 2'b10
    } isbf_size_t;

    // ==========================================================
    // Address regions seen by the fault checker
    // ==========================================================
    localparam logic [31:0] FLASH_BASE = 32'h0800_0000;
    localparam logic [31:0] FLASH_TOP = 32'h0801_ffff;
    localparam logic [31:0] FLASH_WIN_END = 32'h0fff_ffff;
    localparam logic [31:0] RAM_BASE = 32'h2000_0000;
    localparam logic [31:0] RAM_TOP = 32'h2000_1fff;
    localparam logic [31:0] RAM_WIN_END = 32'h3fff_ffff;
    localparam logic [31:0] PROT_RAM_TOP = 32'h2000_03ff;
    localparam logic [31:0] APB_BASE = 32'h4000_0000;
    localparam logic [31:0] APB_END = 32'h4000_ffff;
    localparam logic [31:0] SYS_APB_END = 32'h4000_3fff;
    localparam logic [31:0] SYS_AHB_BASE = 32'he000_0000;
    localparam logic [31:0] SYS_AHB_END = 32'he00f_ffff;
    localparam logic [11:0] APB_LAST_OFS = 12'h0fc;
    localparam logic [1:0] WORD_ALIGN = 2'b00;

endpackage

// file: isbf_top.sv
`timescale 1ns/10ps
module isbf_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [16:0] src_event,
    input wire logic [16:0] src_taken,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic [1:0] acc_size,
    input wire logic acc_write,
    input wire logic acc_priv,
    output logic [16:0] active_flags,
    output logic bus_fault,
    output logic irq
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic addr_hit(input logic [31:0] adr, input logic [31:0] ofs);
        addr_hit = (adr == ofs);
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    logic [16:0] active_q;
    logic [16:0] missed_q;
    logic [3:0] fault_q;
    logic [3:0] fault_d;
    logic [1:0] evt_q;
    logic [1:0] evt_d;
    logic [1:0] emask_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic fault_pulse_q;
    logic irq_q;

    logic req;
    logic wr_take;
    logic [31:0] wr_bits;
    logic [16:0] clr_active;
    logic [16:0] clr_missed;
    logic [3:0] clr_fault;
    logic [1:0] clr_evt;
    logic width_fault;
    logic prot_fault;
    logic rsvd_fault;
    logic fault_hit;
    logic missed_hit;

    // ==========================================================
    // Bus decode
    // ==========================================================
    // A write lands at the edge where the master sees ack, so data and address are
    // guaranteed stable; the read word is captured one edge earlier with the ack.
    always_comb begin
        req = wb_cyc_i && wb_stb_i;
        wr_take = req && wb_we_i && ack_q;
        wr_bits = wb_dat_i & lane_mask(wb_sel_i);
        clr_active = '0;
        clr_missed = '0;
        clr_fault = '0;
        clr_evt = '0;
        if (wr_take && addr_hit(wb_adr_i, isbf_pkg::ADDR_ACTIVE)) begin
            clr_active = wr_bits[16:0];
        end else if (wr_take && addr_hit(wb_adr_i, isbf_pkg::ADDR_MISSED)) begin
            clr_missed = wr_bits[16:0] & isbf_pkg::MISSED_MASK;
        end else if (wr_take && addr_hit(wb_adr_i, isbf_pkg::ADDR_FAULT)) begin
            clr_fault = wr_bits[3:0];
        end else if (wr_take && addr_hit(wb_adr_i, isbf_pkg::ADDR_EVT_STATUS)) begin
            clr_evt = wr_bits[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dat_q <= isbf_pkg::RESET_ZERO;
        end else if (req && !ack_q) begin
            if (addr_hit(wb_adr_i, isbf_pkg::ADDR_ACTIVE)) begin
                dat_q <= {15'h0000, active_q};
            end else if (addr_hit(wb_adr_i, isbf_pkg::ADDR_MISSED)) begin
                dat_q <= {15'h0000, missed_q};
            end else if (addr_hit(wb_adr_i, isbf_pkg::ADDR_FAULT)) begin
                dat_q <= {28'h000_0000, fault_q};
            end else if (addr_hit(wb_adr_i, isbf_pkg::ADDR_EVT_STATUS)) begin
                dat_q <= {30'h0000_0000, evt_q};
            end else if (addr_hit(wb_adr_i, isbf_pkg::ADDR_EVT_MASK)) begin
                dat_q <= {30'h0000_0000, emask_q};
            end else begin
                dat_q <= isbf_pkg::RESET_ZERO;
            end
        end
    end

    // ==========================================================
    // Active and missed flags
    // ==========================================================
    // Set wins over a clear in the same cycle so no event is lost.
    for (genvar i = 0; i < isbf_pkg::NUM_SRC; i++) begin : g_src
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                active_q[i] <= 1'b0;
            end else if (src_event[i]) begin
                active_q[i] <= 1'b1;
            end else if (src_taken[i] || clr_active[i]) begin
                active_q[i] <= 1'b0;
            end
        end

        if (i >= isbf_pkg::MISS_LO && i <= isbf_pkg::MISS_HI) begin : g_miss
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    missed_q[i] <= 1'b0;
                end else if (src_event[i] && active_q[i]) begin
                    missed_q[i] <= 1'b1;
                end else if (clr_missed[i]) begin
                    missed_q[i] <= 1'b0;
                end
            end
        end else begin : g_nomiss
            always_comb begin
                missed_q[i] = 1'b0;
            end
        end
    end

    assign missed_hit = |(src_event & active_q & isbf_pkg::MISSED_MASK);

    // ==========================================================
    // Bus fault cause
    // ==========================================================
    isbf_fault_check u_check (
        .acc_addr(acc_addr),
        .acc_size(acc_size),
        .acc_write(acc_write),
        .acc_priv(acc_priv),
        .width_fault(width_fault),
        .prot_fault(prot_fault),
        .rsvd_fault(rsvd_fault)
    );

    always_comb begin
        fault_hit = acc_valid && (width_fault || prot_fault || rsvd_fault);
        fault_d = fault_q & ~clr_fault;
        if (fault_hit) begin
            fault_d[isbf_pkg::FLT_WIDTH] = fault_d[isbf_pkg::FLT_WIDTH] | width_fault;
            fault_d[isbf_pkg::FLT_PROTECT] = fault_d[isbf_pkg::FLT_PROTECT] | prot_fault;
            fault_d[isbf_pkg::FLT_RESERVED] = fault_d[isbf_pkg::FLT_RESERVED] | rsvd_fault;
            // Overflow looks at the register before this cycle's clear.
            fault_d[isbf_pkg::FLT_OVERFLOW] = fault_d[isbf_pkg::FLT_OVERFLOW] | (|fault_q);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_q <= 4'h0;
        end else begin
            fault_q <= fault_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_pulse_q <= 1'b0;
        end else begin
            fault_pulse_q <= fault_hit;
        end
    end

    // ==========================================================
    // Event status, mask and interrupt
    // ==========================================================
    always_comb begin
        evt_d = evt_q & ~clr_evt;
        evt_d[isbf_pkg::EVT_MISSED] = evt_d[isbf_pkg::EVT_MISSED] | missed_hit;
        evt_d[isbf_pkg::EVT_FAULT] = evt_d[isbf_pkg::EVT_FAULT] | fault_hit;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            evt_q <= 2'h0;
        end else begin
            evt_q <= evt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            emask_q <= 2'h0;
        end else if (wr_take && addr_hit(wb_adr_i, isbf_pkg::ADDR_EVT_MASK)) begin
            emask_q <= wb_sel_i[0] ? wr_bits[1:0] : emask_q;
        end
    end

    // Driven from the next status value so the line rises with the status bit.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_d & emask_q);
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign active_flags = active_q;
    assign bus_fault = fault_pulse_q;
    assign irq = irq_q;

endmodule

// file: isbf_top_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
// ==========================================================
module isbf_top_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic [16:0] src_event,
    input wire logic [16:0] src_taken,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic [1:0] acc_size,
    input wire logic acc_write,
    input wire logic acc_priv,
    input wire logic [16:0] active_flags,
    input wire logic bus_fault
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [16:0] set_q;
    logic [16:0] hold_q;
    logic clr_wr;

    // A bus write to the active register may clear any bit, so holding is only expected outside it.
    assign clr_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == isbf_pkg::ADDR_ACTIVE;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            set_q <= 17'h0_0000;
            hold_q <= 17'h0_0000;
        end else begin
            set_q <= src_event & ~src_taken;
            hold_q <= clr_wr ? 17'h0_0000 : active_flags & ~src_taken;
        end
    end

    sequence apb_acc;
        acc_valid && acc_addr >= isbf_pkg::APB_BASE && acc_addr <= isbf_pkg::APB_END;
    endsequence

    ack_rise_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    act_low_a: assert property ((active_flags & set_q & 17'h1_f003) == (set_q & 17'h1_f003))
        else $error("timer, line or debug active bit not set");
    act_mid_a: assert property ((active_flags & set_q & 17'h0_0ffc) == (set_q & 17'h0_0ffc))
        else $error("peripheral active bit not set");
    act_hold_a: assert property ((active_flags & hold_q) == hold_q)
        else $error("active bit dropped without clear");
    narrow_fault_a: assert property (apb_acc ##0 (acc_size != isbf_pkg::ISBF_SIZE_WORD) |=> bus_fault)
        else $error("narrow peripheral access did not fault");
    unaligned_fault_a: assert property (apb_acc ##0 (acc_addr[1:0] != 2'h0) |=> bus_fault)
        else $error("unaligned peripheral access did not fault");
    rsvd_block_a: assert property (apb_acc ##0 (acc_addr[11:0] > isbf_pkg::APB_LAST_OFS) |=> bus_fault)
        else $error("access above last register did not fault");
    prot_fault_a: assert property (acc_valid && acc_write && !acc_priv && acc_addr >= isbf_pkg::APB_BASE
        && acc_addr <= isbf_pkg::SYS_APB_END |=> bus_fault)
        else $error("unprivileged system write did not fault");
    ram_top_a: assert property (acc_valid && acc_addr > isbf_pkg::RAM_TOP && acc_addr <= isbf_pkg::RAM_WIN_END
        |=> bus_fault)
        else $error("access above ram did not fault");
    quiet_fault_a: assert property (!acc_valid |=> !bus_fault)
        else $error("fault without access");
endmodule

bind isbf_top isbf_top_asserts chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
    .src_event, .src_taken, .acc_valid, .acc_addr, .acc_size, .acc_write, .acc_priv, .active_flags, .bus_fault);

// file: testbench.sv
`timescale 1ns/10ps
// ==========================================================
// Testbench
// ==========================================================
module testbench;
    logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, acc_addr, rd;
    logic [3:0] wb_sel_i;
    logic acc_valid, acc_write, acc_priv, bus_fault, irq;
    logic [16:0] src_event, src_taken, active_flags, exp_act;
    logic [1:0] acc_size;
    int err_total, n_compared;
    logic [31:0] fa[6] = '{32'h4000_0010, 32'h4000_4012, 32'h4000_0010, 32'h4000_5100, 32'h2000_2000, 32'h0802_0000};
    logic [1:0] fs[6] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1};
    logic fw[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic fp[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [31:0] fe[6] = '{32'h8, 32'h8, 32'h4, 32'h2, 32'h2, 32'h2};

    isbf_top uut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .src_event, .src_taken, .acc_valid, .acc_addr, .acc_size, .acc_write, .acc_priv,
        .active_flags, .bus_fault, .irq);
    isbf_core_model core (.clk, .src_event, .src_taken, .acc_valid, .acc_addr, .acc_size, .acc_write, .acc_priv);

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (i == 16) begin
            $display("MISMATCH at %0t: no bus answer", $time);
            err_total++;
            results();
        end
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        sys_rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 32'h0000_0000;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'hf;
        err_total = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(isbf_pkg::ADDR_ACTIVE, 32'h0);
        rdchk(isbf_pkg::ADDR_MISSED, 32'h0);
        rdchk(isbf_pkg::ADDR_FAULT, 32'h0);
        rdchk(32'h0000_0500, 32'h0);
        exp_act = 17'h0_0000;
        for (int k = 0; k < isbf_pkg::NUM_SRC; k++) begin
            core.pulse(17'h0_0001 << k, 17'h0_0000);
            exp_act[k] = 1'b1;
            #1 chk({15'h0, active_flags}, {15'h0, exp_act});
        end
        rdchk(isbf_pkg::ADDR_MISSED, 32'h0);
        wb(1'b1, isbf_pkg::ADDR_EVT_MASK, 32'h1);
        // Every source signals again while still active, so each one that has a missed flag must record it.
        core.pulse(17'h1_ffff, 17'h0_0000);
        rdchk(isbf_pkg::ADDR_MISSED, 32'h0000_fffc);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, isbf_pkg::ADDR_EVT_STATUS, 32'h1);
        @(posedge clk);
        #1 chk({31'h0, irq}, 32'h0);
        wb(1'b1, isbf_pkg::ADDR_EVT_MASK, 32'h0);
        core.pulse(17'h0_0004, 17'h0_0000);
        rdchk(isbf_pkg::ADDR_EVT_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, isbf_pkg::ADDR_EVT_MASK, 32'h1);
        @(posedge clk);
        #1 chk({31'h0, irq}, 32'h1);
        wb(1'b1, isbf_pkg::ADDR_MISSED, 32'h0);
        rdchk(isbf_pkg::ADDR_MISSED, 32'h0000_fffc);
        wb(1'b1, isbf_pkg::ADDR_MISSED, 32'h4);
        rdchk(isbf_pkg::ADDR_MISSED, 32'h0000_fff8);
        // With no byte lane selected the clear must not reach any flag.
        wb_sel_i <= 4'h0;
        wb(1'b1, isbf_pkg::ADDR_MISSED, 32'hffff_ffff);
        wb_sel_i <= 4'hf;
        rdchk(isbf_pkg::ADDR_MISSED, 32'h0000_fff8);
        wb(1'b1, isbf_pkg::ADDR_MISSED, 32'hffff_ffff);
        rdchk(isbf_pkg::ADDR_MISSED, 32'h0);
        core.pulse(17'h0_0000, 17'h0_00ff);
        #1 chk({15'h0, active_flags}, 32'h0001_ff00);
        wb(1'b1, isbf_pkg::ADDR_ACTIVE, 32'h0001_ff00);
        rdchk(isbf_pkg::ADDR_ACTIVE, 32'h0);
        wb(1'b1, isbf_pkg::ADDR_EVT_STATUS, 32'h3);
        wb(1'b1, isbf_pkg::ADDR_EVT_MASK, 32'h2);
        rdchk(isbf_pkg::ADDR_EVT_MASK, 32'h2);
        // The last entry runs without a clear first, so it also exercises the overflow bit.
        for (int k = 0; k < 6; k++) begin
            if (k < 5) wb(1'b1, isbf_pkg::ADDR_FAULT, 32'hf);
            core.access(fa[k], fs[k], fw[k], fp[k]);
            #1 chk({31'h0, bus_fault}, 32'h1);
            rdchk(isbf_pkg::ADDR_FAULT, fe[k] | ((k == 5) ? 32'h1 : 32'h0));
        end
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, isbf_pkg::ADDR_FAULT, 32'hf);
        wb(1'b1, isbf_pkg::ADDR_EVT_STATUS, 32'h2);
        core.access(32'h4000_0010, 2'h2, 1'b0, 1'b1);
        #1 chk({31'h0, bus_fault}, 32'h0);
        rdchk(isbf_pkg::ADDR_FAULT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        results();
    end
endmodule
